// [hprc_params.svh]
`ifndef HPRC_PARAMS_SVH
`define HPRC_PARAMS_SVH

`define HPRC_ADDR_CFG3        8'h08
`define HPRC_ADDR_REMAP       8'hfb
`define HPRC_ADDR_CTRL        8'hff
`define HPRC_PROT_LAST        8'hfe
`define HPRC_CFG3_RESET       8'h00
`define HPRC_REMAP_RESET      8'h21
`define HPRC_CTRL_RESET       8'h00
`define HPRC_CFG3_MAP_EN_BIT  3
`define HPRC_CTRL_PWDN_BIT    2
`define HPRC_CTRL_SRST_BIT    1
`define HPRC_CTRL_ATTACH_BIT  0
`define HPRC_CTRL_USED_MASK   8'h07
`define HPRC_FIELD_DISABLED   4'h0
`define HPRC_FIELD_LOGICAL1   4'h1
`define HPRC_FIELD_LOGICAL2   4'h2
`define HPRC_DEFAULT_LOG_P1   2'h1
`define HPRC_DEFAULT_LOG_P2   2'h2

`endif

// [hprc_pkg.sv]
package hprc_pkg;
    typedef enum logic [1:0] {
        HPRC_LOAD,
        HPRC_ATTACHED,
        HPRC_SLEEP
    } hprc_state_t;
endpackage

// [hprc_port_map.sv]
`timescale 1ns/1ps
`include "hprc_params.svh"

module hprc_port_map (
    // Field and mode
    input  wire logic [3:0] field,
    input  wire logic       map_en,
    input  wire logic [1:0] default_num,
    // Result
    output logic      [1:0] logical_num,
    output logic            illegal
);
    wire logic [1:0] mapped_num;

    assign illegal     = (field > `HPRC_FIELD_LOGICAL2);
    // Illegal code leaves the port disabled rather than guessing
    assign mapped_num  = illegal ? 2'h0 : field[1:0];
    assign logical_num = map_en ? mapped_num : default_num;
endmodule

// [hprc_regs.sv]
`timescale 1ns/1ps
`include "hprc_params.svh"

module hprc_regs
    import hprc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Register access from the serial slave engine
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       xfer_ack_done,
    output logic      [7:0] reg_rdata,
    // Status toward hub core
    output logic      [1:0] port1_logical,
    output logic      [1:0] port2_logical,
    output logic      [1:0] port_count,
    output logic            remap_illegal,
    output logic            usb_attach,
    output logic            serial_if_active,
    output logic            serial_if_reset,
    output logic            write_protect
);
    hprc_state_t state;
    hprc_state_t next_state;

    logic [7:0] cfg3;
    logic [7:0] port_pair_mapping_field;
    logic [7:0] ctrl;
    logic       pwdn_pending;
    logic       srst;

    wire logic       hit_cfg3;
    wire logic       hit_remap;
    wire logic       hit_ctrl;
    wire logic       protect;
    wire logic       wr_cfg3;
    wire logic       wr_remap;
    wire logic       wr_ctrl;
    wire logic       remap_mode_enable;
    wire logic       serial_if_power_down;
    wire logic [7:0] read_mux;
    wire logic [1:0] p1_num;
    wire logic [1:0] p2_num;
    wire logic       p1_bad;
    wire logic       p2_bad;
    wire logic       if_live;

    assign hit_cfg3  = (reg_addr == `HPRC_ADDR_CFG3);
    assign hit_remap = (reg_addr == `HPRC_ADDR_REMAP);
    assign hit_ctrl  = (reg_addr == `HPRC_ADDR_CTRL);
    assign protect   = ctrl[`HPRC_CTRL_ATTACH_BIT]
                       && (reg_addr <= `HPRC_PROT_LAST);
    // Writes need a live interface; disabled or protected are dropped
    assign if_live  = (state != HPRC_SLEEP);
    assign wr_cfg3  = reg_wr && if_live && hit_cfg3 && !protect;
    assign wr_remap = reg_wr && if_live && hit_remap && !protect;
    assign wr_ctrl  = reg_wr && if_live && hit_ctrl;

    assign remap_mode_enable    = cfg3[`HPRC_CFG3_MAP_EN_BIT];
    assign serial_if_power_down = ctrl[`HPRC_CTRL_PWDN_BIT];

    // Unmapped addresses read zero
    assign read_mux = hit_cfg3  ? cfg3 :
                      hit_remap ? port_pair_mapping_field :
                      hit_ctrl  ? ctrl : 8'h00;

    hprc_port_map u_map_p1 (
        .field       (port_pair_mapping_field[3:0]),
        .map_en      (remap_mode_enable),
        .default_num (`HPRC_DEFAULT_LOG_P1),
        .logical_num (p1_num),
        .illegal     (p1_bad)
    );

    hprc_port_map u_map_p2 (
        .field       (port_pair_mapping_field[7:4]),
        .map_en      (remap_mode_enable),
        .default_num (`HPRC_DEFAULT_LOG_P2),
        .logical_num (p2_num),
        .illegal     (p2_bad)
    );

    // Soft reset: one cycle pulse returns every register to default
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            srst <= 1'b0;
        end else begin
            srst <= wr_ctrl && reg_wdata[`HPRC_CTRL_SRST_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg3                    <= `HPRC_CFG3_RESET;
            port_pair_mapping_field <= `HPRC_REMAP_RESET;
        end else if (srst) begin
            cfg3                    <= `HPRC_CFG3_RESET;
            port_pair_mapping_field <= `HPRC_REMAP_RESET;
        end else begin
            if (wr_cfg3) begin
                cfg3 <= reg_wdata;
            end
            if (wr_remap) begin
                port_pair_mapping_field <= reg_wdata;
            end
        end
    end

    // Reserved bits masked; the reset bit self-clears
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= `HPRC_CTRL_RESET;
        end else if (srst) begin
            ctrl <= `HPRC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata & `HPRC_CTRL_USED_MASK
                    & ~(8'h01 << `HPRC_CTRL_SRST_BIT);
        end
    end

    // Power-down waits for the acknowledge of its own transfer;
    // the arming write wins, as the stored bit is still old here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwdn_pending <= 1'b0;
        end else if (srst) begin
            pwdn_pending <= 1'b0;
        end else if (wr_ctrl && reg_wdata[`HPRC_CTRL_PWDN_BIT]) begin
            pwdn_pending <= 1'b1;
        end else if (wr_ctrl || xfer_ack_done || !serial_if_power_down) begin
            pwdn_pending <= 1'b0;
        end
    end

    // No timeout on the load: attach only on software request
    always_comb begin
        next_state = state;
        case (state)
            HPRC_LOAD: begin
                if (pwdn_pending && xfer_ack_done) begin
                    next_state = HPRC_SLEEP;
                end else if (ctrl[`HPRC_CTRL_ATTACH_BIT]) begin
                    next_state = HPRC_ATTACHED;
                end
            end
            HPRC_ATTACHED: begin
                if (pwdn_pending && xfer_ack_done) begin
                    next_state = HPRC_SLEEP;
                end else if (!ctrl[`HPRC_CTRL_ATTACH_BIT]) begin
                    next_state = HPRC_LOAD;
                end
            end
            HPRC_SLEEP: begin
                if (!serial_if_power_down) begin
                    next_state = HPRC_LOAD;
                end
            end
            default: next_state = HPRC_LOAD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= HPRC_LOAD;
        end else begin
            state <= next_state;
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata        <= 8'h00;
            port1_logical    <= `HPRC_DEFAULT_LOG_P1;
            port2_logical    <= `HPRC_DEFAULT_LOG_P2;
            port_count       <= 2'h2;
            remap_illegal    <= 1'b0;
            usb_attach       <= 1'b0;
            serial_if_active <= 1'b1;
            serial_if_reset  <= 1'b0;
            write_protect    <= 1'b0;
        end else begin
            reg_rdata        <= reg_rd ? read_mux : 8'h00;
            port1_logical    <= p1_num;
            port2_logical    <= p2_num;
            // Only the count goes upstream; host assigns numbers
            port_count       <= {1'b0, (p1_num != 2'h0)}
                                + {1'b0, (p2_num != 2'h0)};
            remap_illegal    <= remap_mode_enable && (p1_bad || p2_bad);
            usb_attach       <= (next_state == HPRC_ATTACHED)
                                || (state == HPRC_SLEEP
                                    && ctrl[`HPRC_CTRL_ATTACH_BIT]);
            serial_if_active <= (next_state != HPRC_SLEEP);
            serial_if_reset  <= srst;
            write_protect    <= ctrl[`HPRC_CTRL_ATTACH_BIT];
        end
    end

    // Assertions
    a_protect_blocks: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl[0] && reg_wr && hit_remap |=> $stable(port_pair_mapping_field))
        else $error("protected write changed remap");
    a_ctrl_writable: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ctrl && !srst && reg_wdata[0] |=> ctrl[0])
        else $error("attach bit not written");
    a_srst_defaults: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ctrl && reg_wdata[1] |=> ##1
        port_pair_mapping_field == `HPRC_REMAP_RESET && ctrl == 8'h00)
        else $error("soft reset did not restore");
    a_undef_zero: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && !hit_cfg3 && !hit_remap && !hit_ctrl |=> reg_rdata == 8'h00)
        else $error("undefined read nonzero");
    a_default_map: assert property (@(posedge clk) disable iff (!rst_b)
        !remap_mode_enable |=> port1_logical == 2'h1 && port2_logical == 2'h2)
        else $error("default numbering lost");
    a_map_p2: assert property (@(posedge clk) disable iff (!rst_b)
        remap_mode_enable && port_pair_mapping_field[7:4] == 4'h2
        |=> port2_logical == 2'h2)
        else $error("port two mapping wrong");
    a_map_p1: assert property (@(posedge clk) disable iff (!rst_b)
        remap_mode_enable && port_pair_mapping_field[3:0] == 4'h0
        |=> port1_logical == 2'h0)
        else $error("port one not disabled");
    a_pwdn_after_ack: assert property (@(posedge clk) disable iff (!rst_b)
        pwdn_pending && xfer_ack_done && serial_if_power_down && !srst
        |=> !serial_if_active)
        else $error("interface not powered down");
    a_detached_idle: assert property (@(posedge clk) disable iff (!rst_b)
        state == HPRC_LOAD && !ctrl[0] && !pwdn_pending
        |=> !usb_attach && serial_if_active)
        else $error("attached before load done");
endmodule

// [hprc_host_model.sv]
`timescale 1ns/1ps

module hprc_host_model (
    // Clock
    input  wire logic       clk,
    // Register access
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            xfer_ack_done,
    // Read return
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        xfer_ack_done = 1'b0;
    end

    // Released lines flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = (a == 8'hff) ? (d & 8'h07) : d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        d = reg_rdata;
    endtask

    task automatic ack;
        @(posedge clk);
        #1;
        xfer_ack_done = 1'b1;
        @(posedge clk);
        #1;
        xfer_ack_done = 1'b0;
    endtask
endmodule

// [hprc_regs_tb_top.sv]
`timescale 1ns/1ps

module hprc_regs_tb_top;
    typedef struct packed {
        logic [7:0] d;
        logic [6:0] o;
    } hprc_row_t;

    logic       clk;
    logic       rst_b;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       xfer_ack_done;
    logic [7:0] reg_rdata;
    logic [1:0] port1_logical;
    logic [1:0] port2_logical;
    logic [1:0] port_count;
    logic       remap_illegal;
    logic       usb_attach;
    logic       serial_if_active;
    logic       serial_if_reset;
    logic       write_protect;
    logic [7:0] rd;
    int         failures;
    int         compares;
    hprc_row_t  rows [7];
    wire  [7:0] outs = {1'b0, port1_logical, port2_logical, port_count,
                        remap_illegal};
    wire  [7:0] stat = {5'h0, usb_attach, write_protect, serial_if_active};

    hprc_regs u_hprc_regs (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .xfer_ack_done(xfer_ack_done), .reg_rdata(reg_rdata),
        .port1_logical(port1_logical), .port2_logical(port2_logical),
        .port_count(port_count), .remap_illegal(remap_illegal),
        .usb_attach(usb_attach), .serial_if_active(serial_if_active),
        .serial_if_reset(serial_if_reset), .write_protect(write_protect));

    hprc_host_model u_hprc_host_model (.clk(clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .xfer_ack_done(xfer_ack_done), .reg_rdata(reg_rdata));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic final_report;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        // Contiguous numbering first, illegal codes last
        rows = '{'{8'h21, 7'h34}, '{8'h12, 7'h4c}, '{8'h01, 7'h22},
                 '{8'h10, 7'h0a}, '{8'h00, 7'h00}, '{8'h31, 7'h23},
                 '{8'h0f, 7'h01}};
        rst_b = 1'b0;
        failures = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk(outs, 8'h34);
        chk(stat, 8'h01);
        u_hprc_host_model.rd(8'hfb, rd);
        chk(rd, 8'h21);
        u_hprc_host_model.rd(8'hff, rd);
        chk(rd, 8'h00);
        u_hprc_host_model.wr(8'h40, 8'h5a);
        u_hprc_host_model.rd(8'h40, rd);
        chk(rd, 8'h00);
        u_hprc_host_model.wr(8'hfb, 8'h12);
        wt(3);
        chk(outs, 8'h34);
        u_hprc_host_model.wr(8'h08, 8'h08);
        for (int i = 0; i < 7; i++) begin
            u_hprc_host_model.wr(8'hfb, rows[i].d);
            wt(3);
            chk(outs, {1'b0, rows[i].o});
            u_hprc_host_model.rd(8'hfb, rd);
            chk(rd, rows[i].d);
        end
        // Soft reset pulse is one cycle wide, so poll every edge
        u_hprc_host_model.wr(8'hff, 8'h02);
        for (int k = 0; k < 8 && serial_if_reset !== 1'b1; k++) wt(1);
        chk({7'h0, serial_if_reset}, 8'h01);
        wt(2);
        chk(outs, 8'h34);
        u_hprc_host_model.rd(8'h08, rd);
        chk(rd, 8'h00);
        wt(40);
        chk(stat, 8'h01);
        u_hprc_host_model.wr(8'hff, 8'h01);
        wt(3);
        chk(stat, 8'h07);
        u_hprc_host_model.wr(8'hfb, 8'h00);
        u_hprc_host_model.rd(8'hfb, rd);
        chk(rd, 8'h21);
        u_hprc_host_model.wr(8'hff, 8'h05);
        wt(3);
        chk(stat, 8'h07);
        u_hprc_host_model.rd(8'hff, rd);
        chk(rd, 8'h05);
        u_hprc_host_model.ack;
        wt(2);
        chk({7'h0, serial_if_active}, 8'h00);
        u_hprc_host_model.wr(8'hff, 8'h00);
        wt(3);
        chk({6'h0, usb_attach, serial_if_active}, 8'h02);
        // Only the reset pin wakes a sleeping interface
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk(stat, 8'h01);
        chk(outs, 8'h34);
        u_hprc_host_model.rd(8'hff, rd);
        chk(rd, 8'h00);
        final_report;
    end
endmodule
